// >>> rtlld_pkg.sv
/*
 * Shared constants for the reset option and trim loader: flash addresses of
 * the option bytes and factory trim bytes, option field positions, erased
 * values, APB register map, divider ratio and loader state codes.
 * Assumes a byte-wide flash read port and an APB slave with a 12-bit address.
 */
`default_nettype none
package rtlld_pkg;

    // Flash side
    localparam int          FLASH_AW           = 16;
    localparam logic [15:0] OPT_ADDR_MOTOR     = 16'h0001;
    localparam logic [15:0] OPT_ADDR_BUS_POWER = 16'h0003;
    localparam logic [15:0] INFO_ADDR_TRIM_1   = 16'h0021;
    localparam logic [15:0] INFO_ADDR_TRIM_2   = 16'h0022;
    localparam logic [7:0]  ERASED_BYTE        = 8'hFF;

    // Option byte at 0001h
    localparam int MOTOR_PINS_ENABLE_N_BIT = 2;
    localparam int HIGH_SIDE_OFF_BIT       = 1;
    localparam int LOW_SIDE_OFF_BIT        = 0;
    // Option byte at 0003h
    localparam int EXT_BUS_WIDE_BIT        = 7;
    localparam int LOW_POWER_START_N_BIT   = 6;

    // First trim register split: temperature trim high, frequency trim low
    localparam int TEMP_TRIM_W = 3;
    localparam int FREQ_TRIM_W = 5;

    // Start-up clock divider
    localparam int         DIV_RATIO  = 8;
    localparam logic [2:0] DIV_LAST   = 3'h7;

    // APB map: printed offsets kept as indices, byte address is four times index
    localparam int          PADDR_W            = 12;
    localparam logic [31:0] IDX_TRIM_FIRST     = 32'hFFFFFF25;
    localparam logic [31:0] IDX_TRIM_SECOND    = 32'hFFFFFF26;
    localparam logic [31:0] IDX_FACTORY_FIRST  = 32'h00000021;
    localparam logic [31:0] IDX_FACTORY_SECOND = 32'h00000022;
    localparam logic [31:0] IDX_STATUS         = 32'h00000030;
    localparam logic [11:0] ADDR_TRIM_FIRST     = {IDX_TRIM_FIRST[9:0], 2'b00};
    localparam logic [11:0] ADDR_TRIM_SECOND    = {IDX_TRIM_SECOND[9:0], 2'b00};
    localparam logic [11:0] ADDR_FACTORY_FIRST  = {IDX_FACTORY_FIRST[9:0], 2'b00};
    localparam logic [11:0] ADDR_FACTORY_SECOND = {IDX_FACTORY_SECOND[9:0], 2'b00};
    localparam logic [11:0] ADDR_STATUS         = {IDX_STATUS[9:0], 2'b00};
    localparam int          STAT_LOAD_DONE_BIT  = 0;
    localparam int          STAT_DIV8_BIT       = 1;
    localparam logic [7:0]  TRIM_RESET          = 8'h00;

    // Loader steps
    localparam logic [1:0] STEP_BUS_POWER = 2'h0;
    localparam logic [1:0] STEP_MOTOR     = 2'h1;
    localparam logic [1:0] STEP_TRIM_1    = 2'h2;
    localparam logic [1:0] STEP_TRIM_2    = 2'h3;

    typedef enum logic [2:0] {
        LD_ISSUE = 3'b001,
        LD_WAIT  = 3'b010,
        LD_DONE  = 3'b100
    } rtlld_ld_state_t;

    typedef enum logic [2:0] {
        FT_IDLE    = 3'b001,
        FT_STROBE  = 3'b010,
        FT_CAPTURE = 3'b100
    } rtlld_ft_state_t;

    typedef enum logic [2:0] {
        RK_NONE    = 3'h0,
        RK_TRIM1   = 3'h1,
        RK_TRIM2   = 3'h2,
        RK_FACT1   = 3'h3,
        RK_FACT2   = 3'h4,
        RK_STATUS  = 3'h5
    } rtlld_reg_kind_t;

endpackage
`default_nettype wire

// >>> rtlld_fetch_if.sv
/*
 * Request and answer between the loader and its flash fetch unit.
 * Assumes both ends run on the same clock; req is held until ack pulses.
 */
`timescale 1ns/1ns
`default_nettype none
interface rtlld_fetch_if;
    logic        req;
    logic [15:0] addr;
    logic        info_sel;
    logic        ack;
    logic [7:0]  data;

    modport loader  (output req, output addr, output info_sel, input ack, input data);
    modport fetcher (input req, input addr, input info_sel, output ack, output data);
endinterface
`default_nettype wire

// >>> rtlld_clkdiv.sv
/*
 * Start-up divide-by-eight phase counter. Gives the cycle in which flash may
 * be accessed: every cycle at full speed, the last phase when divided.
 * Assumes a synchronous active-high reset on the system clock.
 */
`timescale 1ns/1ns
`default_nettype none
module rtlld_clkdiv
    import rtlld_pkg::*;
(
    // Clock and reset
    input  wire logic CLOCK_I,
    input  wire logic SRST_I,
    // Control
    input  wire logic div_en_i,
    output logic      slot_ok_o
);
    logic [2:0] phase_ff;
    logic [2:0] nxt_phase;
    logic       slot_ff;
    logic       nxt_slot;

    always_comb begin
        nxt_phase = div_en_i ? phase_ff + 3'h1 : 3'h0;
        nxt_slot  = ~div_en_i | (nxt_phase == DIV_LAST);
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            phase_ff <= 3'h0;
            slot_ff  <= 1'b1;
        end else begin
            phase_ff <= nxt_phase;
            slot_ff  <= nxt_slot;
        end
    end

    assign slot_ok_o = slot_ff;
endmodule
`default_nettype wire

// >>> rtlld_fetch.sv
/*
 * Flash fetch unit: turns a held request into one read strobe, placed in the
 * cycle after an allowed slot, and returns the byte two cycles after the strobe.
 * Assumes flash drives data in the cycle after its read strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module rtlld_fetch
    import rtlld_pkg::*;
(
    // Clock and reset
    input  wire logic         CLOCK_I,
    input  wire logic         SRST_I,
    // Loader side
    rtlld_fetch_if.fetcher    fif,
    input  wire logic         slot_ok_i,
    // Flash side
    output logic [15:0]       flash_addr_o,
    output logic              flash_info_o,
    output logic              flash_rd_o,
    input  wire logic [7:0]   flash_data_i
);
    rtlld_ft_state_t state_ff;
    rtlld_ft_state_t nxt_state;
    logic [15:0]     addr_ff;
    logic [15:0]     nxt_addr;
    logic            info_ff;
    logic            nxt_info;
    logic            ack_ff;
    logic            nxt_ack;
    logic [7:0]      data_ff;
    logic [7:0]      nxt_data;

    always_comb begin
        nxt_state = state_ff;
        nxt_addr  = addr_ff;
        nxt_info  = info_ff;
        nxt_ack   = 1'b0;
        nxt_data  = data_ff;
        unique case (state_ff)
            FT_IDLE: begin
                if (fif.req && !ack_ff && slot_ok_i) begin
                    nxt_state = FT_STROBE;
                    nxt_addr  = fif.addr;
                    nxt_info  = fif.info_sel;
                end
            end
            FT_STROBE: begin
                nxt_state = FT_CAPTURE;
            end
            FT_CAPTURE: begin
                nxt_state = FT_IDLE;
                nxt_data  = flash_data_i;
                nxt_ack   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            state_ff <= FT_IDLE;
            addr_ff  <= 16'h0000;
            info_ff  <= 1'b0;
            ack_ff   <= 1'b0;
            data_ff  <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            addr_ff  <= nxt_addr;
            info_ff  <= nxt_info;
            ack_ff   <= nxt_ack;
            data_ff  <= nxt_data;
        end
    end

    assign flash_addr_o = addr_ff;
    assign flash_info_o = info_ff;
    assign flash_rd_o   = (state_ff == FT_STROBE);
    assign fif.ack      = ack_ff;
    assign fif.data     = data_ff;
endmodule
`default_nettype wire

// >>> rtlld_loader.sv
/*
 * Reset option and trim loader, top level. After every reset it reads the
 * option bytes at 0003h and 0001h and the factory trim bytes at 0021h and
 * 0022h, holds the core in reset until all are latched, and drives the
 * resulting configuration. Software reaches the trim registers over APB.
 * Assumes the reset controller pulses RELOAD_REQ_I for short resets and
 * stop-mode recovery, on the same clock; flash is on-chip on the same clock.
 */
// Implementation choice: the APB slave port.
// Overview of operation
// - Option bit 0001h[2] low enables motor-control pin functions at reset.
// - High-side PWM off level follows option bit 0001h[1].
// - Low-side PWM off level follows option bit 0001h[0].
// - Option bit 0003h[7] selects 8-bit or 16-bit external data bus.
// - Option bit 0003h[6] low starts divided by 8, flash read in phase 0, after the last-phase slot.
// - Information area contents cannot be written; only runtime registers.
// - Every reset restores factory trims, discarding software overrides.
// - Factory trim readback returns unaltered information area values.
// - First trim register loads at reset: temperature high, frequency low.
// - Second trim register loads at reset; both are software read/write.
// - Every reset type fetches option bytes into configuration registers.
// - Configuration is fully loaded before the core leaves reset.
// - Option configuration registers are invisible to software, except the divide-by-8 state in status bit 1.
`timescale 1ns/1ns
`default_nettype none
module rtlld_loader
    import rtlld_pkg::*;
(
    // Clock and reset
    input  wire logic               CLOCK_I,
    input  wire logic               SRST_I,
    input  wire logic               RELOAD_REQ_I,
    // APB slave
    input  wire logic               PSEL_I,
    input  wire logic               PENABLE_I,
    input  wire logic               PWRITE_I,
    input  wire logic [PADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]        PWDATA_I,
    output logic                    PREADY_O,
    output logic [31:0]             PRDATA_O,
    output logic                    PSLVERR_O,
    // Flash read port
    output logic [15:0]             FLASH_ADDR_O,
    output logic                    FLASH_INFO_SEL_O,
    output logic                    FLASH_RD_O,
    input  wire logic [7:0]         FLASH_DATA_I,
    // Configuration outputs
    output logic                    CORE_RESET_O,
    output logic                    MOTOR_PINS_ENABLE_O,
    output logic                    HIGH_SIDE_OFF_LEVEL_O,
    output logic                    LOW_SIDE_OFF_LEVEL_O,
    output logic                    EXTERNAL_BUS_WIDE_SELECT_O,
    output logic                    SYSCLK_DIV8_O,
    output logic [TEMP_TRIM_W-1:0]  OSC_TEMPERATURE_TRIM_O,
    output logic [FREQ_TRIM_W-1:0]  OSC_FREQUENCY_TRIM_O,
    output logic [7:0]              OSC_FREQUENCY_TRIM2_O
);
    rtlld_fetch_if fif ();

    // Loader state
    rtlld_ld_state_t state_ff;
    rtlld_ld_state_t nxt_state;
    logic [1:0]      step_ff;
    logic [1:0]      nxt_step;
    logic            req_ff;
    logic            nxt_req;
    logic            pending_ff;
    logic            nxt_pending;
    logic            core_rst_ff;
    logic            nxt_core_rst;

    // Option configuration, not on the register bus except div_ff as a status bit
    logic [7:0]      opt_motor_ff;
    logic [7:0]      nxt_opt_motor;
    logic [7:0]      opt_bus_ff;
    logic [7:0]      nxt_opt_bus;
    logic            div_ff;
    logic            nxt_div;

    // Trim registers and factory copies
    logic [7:0]      trim1_ff;
    logic [7:0]      nxt_trim1;
    logic [7:0]      trim2_ff;
    logic [7:0]      nxt_trim2;
    logic [7:0]      fact1_ff;
    logic [7:0]      nxt_fact1;
    logic [7:0]      fact2_ff;
    logic [7:0]      nxt_fact2;

    // APB
    logic            pready_ff;
    logic            nxt_pready;
    logic [31:0]     prdata_ff;
    logic [31:0]     nxt_prdata;
    logic            pslverr_ff;
    logic            nxt_pslverr;

    logic            slot_ok;
    logic            apb_setup;
    logic            apb_done;
    rtlld_reg_kind_t kind;

    function automatic rtlld_reg_kind_t reg_kind(input logic [PADDR_W-1:0] a);
        rtlld_reg_kind_t k;
        k = RK_NONE;
        if (a == ADDR_TRIM_FIRST) begin
            k = RK_TRIM1;
        end else if (a == ADDR_TRIM_SECOND) begin
            k = RK_TRIM2;
        end else if (a == ADDR_FACTORY_FIRST) begin
            k = RK_FACT1;
        end else if (a == ADDR_FACTORY_SECOND) begin
            k = RK_FACT2;
        end else if (a == ADDR_STATUS) begin
            k = RK_STATUS;
        end
        return k;
    endfunction

    function automatic logic [15:0] step_addr(input logic [1:0] s);
        logic [15:0] a;
        unique case (s)
            STEP_BUS_POWER: a = OPT_ADDR_BUS_POWER;
            STEP_MOTOR:     a = OPT_ADDR_MOTOR;
            STEP_TRIM_1:    a = INFO_ADDR_TRIM_1;
            STEP_TRIM_2:    a = INFO_ADDR_TRIM_2;
        endcase
        return a;
    endfunction

    rtlld_clkdiv u_clkdiv (
        .CLOCK_I   (CLOCK_I),
        .SRST_I    (SRST_I),
        .div_en_i  (div_ff),
        .slot_ok_o (slot_ok)
    );

    rtlld_fetch u_fetch (
        .CLOCK_I      (CLOCK_I),
        .SRST_I       (SRST_I),
        .fif          (fif.fetcher),
        .slot_ok_i    (slot_ok),
        .flash_addr_o (FLASH_ADDR_O),
        .flash_info_o (FLASH_INFO_SEL_O),
        .flash_rd_o   (FLASH_RD_O),
        .flash_data_i (FLASH_DATA_I)
    );

    assign fif.req      = req_ff;
    assign fif.addr     = step_addr(step_ff);
    assign fif.info_sel = step_ff[1];

    assign apb_setup = PSEL_I & ~PENABLE_I;
    assign apb_done  = PSEL_I & PENABLE_I & pready_ff;
    assign kind      = reg_kind(PADDR_I);

    // Loader sequence: 0003h first so the divider governs the later reads
    always_comb begin
        nxt_state     = state_ff;
        nxt_step      = step_ff;
        nxt_req       = req_ff;
        nxt_core_rst  = core_rst_ff;
        nxt_opt_motor = opt_motor_ff;
        nxt_opt_bus   = opt_bus_ff;
        nxt_div       = div_ff;
        nxt_fact1     = fact1_ff;
        nxt_fact2     = fact2_ff;
        nxt_pending   = pending_ff;
        unique case (state_ff)
            LD_ISSUE: begin
                nxt_req   = 1'b1;
                nxt_state = LD_WAIT;
            end
            LD_WAIT: begin
                if (fif.ack) begin
                    nxt_req = 1'b0;
                    unique case (step_ff)
                        STEP_BUS_POWER: begin
                            nxt_opt_bus = fif.data;
                            nxt_div     = ~fif.data[LOW_POWER_START_N_BIT];
                        end
                        STEP_MOTOR:  nxt_opt_motor = fif.data;
                        STEP_TRIM_1: nxt_fact1     = fif.data;
                        STEP_TRIM_2: nxt_fact2     = fif.data;
                    endcase
                    if (pending_ff) begin
                        nxt_state   = LD_ISSUE;
                        nxt_step    = STEP_BUS_POWER;
                        nxt_div     = 1'b0;
                        nxt_pending = 1'b0;
                    end else if (step_ff == STEP_TRIM_2) begin
                        nxt_state    = LD_DONE;
                        nxt_core_rst = 1'b0;
                    end else begin
                        nxt_state = LD_ISSUE;
                        nxt_step  = step_ff + 2'h1;
                    end
                end
            end
            LD_DONE: begin
                if (pending_ff) begin
                    nxt_state    = LD_ISSUE;
                    nxt_step     = STEP_BUS_POWER;
                    nxt_core_rst = 1'b1;
                    nxt_div      = 1'b0;
                    nxt_pending  = 1'b0;
                end
            end
        endcase
        if (RELOAD_REQ_I) begin
            nxt_pending = 1'b1;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            state_ff     <= LD_ISSUE;
            step_ff      <= STEP_BUS_POWER;
            req_ff       <= 1'b0;
            pending_ff   <= 1'b0;
            core_rst_ff  <= 1'b1;
            opt_motor_ff <= ERASED_BYTE;
            opt_bus_ff   <= ERASED_BYTE;
            div_ff       <= 1'b0;
            fact1_ff     <= TRIM_RESET;
            fact2_ff     <= TRIM_RESET;
        end else begin
            state_ff     <= nxt_state;
            step_ff      <= nxt_step;
            req_ff       <= nxt_req;
            pending_ff   <= nxt_pending;
            core_rst_ff  <= nxt_core_rst;
            opt_motor_ff <= nxt_opt_motor;
            opt_bus_ff   <= nxt_opt_bus;
            div_ff       <= nxt_div;
            fact1_ff     <= nxt_fact1;
            fact2_ff     <= nxt_fact2;
        end
    end

    // Runtime trim registers: factory value on each load, then software
    always_comb begin
        nxt_trim1 = trim1_ff;
        nxt_trim2 = trim2_ff;
        if (apb_done && PWRITE_I && kind == RK_TRIM1) begin
            nxt_trim1 = PWDATA_I[7:0];
        end
        if (apb_done && PWRITE_I && kind == RK_TRIM2) begin
            nxt_trim2 = PWDATA_I[7:0];
        end
        if (state_ff == LD_WAIT && fif.ack && step_ff == STEP_TRIM_1) begin
            nxt_trim1 = fif.data;
        end
        if (state_ff == LD_WAIT && fif.ack && step_ff == STEP_TRIM_2) begin
            nxt_trim2 = fif.data;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            trim1_ff <= TRIM_RESET;
            trim2_ff <= TRIM_RESET;
        end else begin
            trim1_ff <= nxt_trim1;
            trim2_ff <= nxt_trim2;
        end
    end

    // APB slave: decode in setup, answer in the first access cycle
    always_comb begin
        nxt_pready  = pready_ff;
        nxt_prdata  = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (apb_setup) begin
            nxt_pready  = 1'b1;
            nxt_prdata  = 32'h00000000;
            nxt_pslverr = 1'b0;
            unique case (kind)
                RK_TRIM1:  nxt_prdata[7:0] = trim1_ff;
                RK_TRIM2:  nxt_prdata[7:0] = trim2_ff;
                RK_FACT1:  nxt_prdata[7:0] = fact1_ff;
                RK_FACT2:  nxt_prdata[7:0] = fact2_ff;
                RK_STATUS: begin
                    nxt_prdata[STAT_LOAD_DONE_BIT] = ~core_rst_ff;
                    nxt_prdata[STAT_DIV8_BIT]      = div_ff;
                end
                default:   nxt_pslverr = 1'b1;
            endcase
            if (PWRITE_I && (kind == RK_FACT1 || kind == RK_FACT2
                             || kind == RK_STATUS)) begin
                nxt_pslverr = 1'b1;
            end
        end else if (apb_done) begin
            nxt_pready  = 1'b0;
            nxt_pslverr = 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= nxt_pready;
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign PREADY_O                   = pready_ff;
    assign PRDATA_O                   = prdata_ff;
    assign PSLVERR_O                  = pslverr_ff;
    assign CORE_RESET_O               = core_rst_ff;
    assign MOTOR_PINS_ENABLE_O        = ~opt_motor_ff[MOTOR_PINS_ENABLE_N_BIT];
    assign HIGH_SIDE_OFF_LEVEL_O      = opt_motor_ff[HIGH_SIDE_OFF_BIT];
    assign LOW_SIDE_OFF_LEVEL_O       = opt_motor_ff[LOW_SIDE_OFF_BIT];
    assign EXTERNAL_BUS_WIDE_SELECT_O = opt_bus_ff[EXT_BUS_WIDE_BIT];
    assign SYSCLK_DIV8_O              = div_ff;
    assign OSC_TEMPERATURE_TRIM_O     = trim1_ff[7 -: TEMP_TRIM_W];
    assign OSC_FREQUENCY_TRIM_O       = trim1_ff[FREQ_TRIM_W-1:0];
    assign OSC_FREQUENCY_TRIM2_O      = trim2_ff;
endmodule
`default_nettype wire

// >>> rtlld_assertions.sv
/*
 * Concurrent checks on the option and trim loader ports.
 * Assumes it is bound into rtlld_loader and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
module rtlld_assertions
    import rtlld_pkg::*;
(
    input wire logic                   CLOCK_I,
    input wire logic                   SRST_I,
    input wire logic                   RELOAD_REQ_I,
    input wire logic                   PSEL_I,
    input wire logic                   PENABLE_I,
    input wire logic                   PREADY_O,
    input wire logic                   PSLVERR_O,
    input wire logic [15:0]            FLASH_ADDR_O,
    input wire logic                   FLASH_INFO_SEL_O,
    input wire logic                   FLASH_RD_O,
    input wire logic [7:0]             FLASH_DATA_I,
    input wire logic                   CORE_RESET_O,
    input wire logic                   MOTOR_PINS_ENABLE_O,
    input wire logic                   HIGH_SIDE_OFF_LEVEL_O,
    input wire logic                   LOW_SIDE_OFF_LEVEL_O,
    input wire logic                   EXTERNAL_BUS_WIDE_SELECT_O,
    input wire logic                   SYSCLK_DIV8_O,
    input wire logic [TEMP_TRIM_W-1:0] OSC_TEMPERATURE_TRIM_O,
    input wire logic [FREQ_TRIM_W-1:0] OSC_FREQUENCY_TRIM_O,
    input wire logic [7:0]             OSC_FREQUENCY_TRIM2_O
);
    logic       rd_ff;
    logic [7:0] opt1_ff;
    logic [7:0] opt3_ff;
    logic [7:0] trim1_ff;
    logic [7:0] trim2_ff;

    // Shadow of each byte as flash hands it over
    always_ff @(posedge CLOCK_I) begin
        rd_ff <= FLASH_RD_O;
        if (rd_ff) begin
            case ({FLASH_INFO_SEL_O, FLASH_ADDR_O})
                {1'b0, OPT_ADDR_MOTOR}:     opt1_ff  <= FLASH_DATA_I;
                {1'b0, OPT_ADDR_BUS_POWER}: opt3_ff  <= FLASH_DATA_I;
                {1'b1, INFO_ADDR_TRIM_1}:   trim1_ff <= FLASH_DATA_I;
                {1'b1, INFO_ADDR_TRIM_2}:   trim2_ff <= FLASH_DATA_I;
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);

    motor_cfg_a: assert property ($fell(CORE_RESET_O) |->
        MOTOR_PINS_ENABLE_O == !opt1_ff[2])
        else $error("motor enable differs from option byte");
    pwm_levels_a: assert property ($fell(CORE_RESET_O) |->
        {HIGH_SIDE_OFF_LEVEL_O, LOW_SIDE_OFF_LEVEL_O} == opt1_ff[1:0])
        else $error("off levels differ from option byte");
    bus_width_a: assert property ($fell(CORE_RESET_O) |->
        EXTERNAL_BUS_WIDE_SELECT_O == opt3_ff[7])
        else $error("bus width differs from option byte");
    div8_start_a: assert property ($fell(CORE_RESET_O) |-> SYSCLK_DIV8_O == !opt3_ff[6])
        else $error("start-up divider differs from option byte");
    div8_slot_a: assert property (FLASH_RD_O && SYSCLK_DIV8_O |=> !FLASH_RD_O [*7])
        else $error("flash read outside the divided slot");
    trim_load_a: assert property ($fell(CORE_RESET_O) |->
        {OSC_TEMPERATURE_TRIM_O, OSC_FREQUENCY_TRIM_O} == trim1_ff &&
        OSC_FREQUENCY_TRIM2_O == trim2_ff)
        else $error("trim outputs differ from factory bytes");
    load_first_a: assert property (FLASH_RD_O |-> CORE_RESET_O)
        else $error("flash read while core runs");
    cfg_stable_a: assert property (!CORE_RESET_O && !$past(CORE_RESET_O) |->
        $stable({MOTOR_PINS_ENABLE_O, HIGH_SIDE_OFF_LEVEL_O, LOW_SIDE_OFF_LEVEL_O,
                 EXTERNAL_BUS_WIDE_SELECT_O, SYSCLK_DIV8_O}))
        else $error("option outputs changed while core runs");
    reload_hold_a: assert property (RELOAD_REQ_I |-> ##[0:3] CORE_RESET_O)
        else $error("reload did not hold the core");
    apb_ready_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("no ready after setup");

    load_end_c: cover property ($fell(CORE_RESET_O));
    div_read_c: cover property (FLASH_RD_O && SYSCLK_DIV8_O);
    refused_c: cover property (PREADY_O && PSLVERR_O);
endmodule
bind rtlld_loader rtlld_assertions u_chk (.*);
`default_nettype wire

// >>> rtlld_flash_model.sv
/*
 * Flash array model: option bytes and factory trim bytes.
 * Assumes one read strobe per byte, data valid in the following cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module rtlld_flash_model
    import rtlld_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        rd_i,
    input  wire logic        info_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  opt1_i,
    input  wire logic [7:0]  opt3_i,
    input  wire logic [7:0]  trim1_i,
    input  wire logic [7:0]  trim2_i,
    output logic      [7:0]  data_o
);
    logic [7:0] byte_sel;

    always_comb begin
        byte_sel = ERASED_BYTE;
        if (!info_i && addr_i == OPT_ADDR_MOTOR) byte_sel = {5'h1F, opt1_i[2:0]};
        if (!info_i && addr_i == OPT_ADDR_BUS_POWER) byte_sel = {opt3_i[7:6], 6'h3F};
        if (info_i && addr_i == INFO_ADDR_TRIM_1) byte_sel = trim1_i;
        if (info_i && addr_i == INFO_ADDR_TRIM_2) byte_sel = trim2_i;
    end

    // Byte valid only in the cycle after the strobe, scrambled otherwise
    always @(posedge CLOCK_I) data_o <= rd_i ? byte_sel : ~data_o;
endmodule
`default_nettype wire

// >>> rtlld_loader_tb.sv
/*
 * Testbench for the option and trim loader: loads, APB access, reload.
 * Assumes the flash model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ns
`default_nettype none
module rtlld_loader_tb;
    import rtlld_pkg::*;
    logic clk, srst, reload, psel, penable, pwrite, pready, pslverr, rd, info, core, e;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] faddr;
    logic [7:0]  fdata, opt1, opt3, t1, t2;
    logic [20:0] cfg;
    int          err_total = 0;
    int          num_checks = 0;

    rtlld_loader u_dut (.CLOCK_I(clk), .SRST_I(srst), .RELOAD_REQ_I(reload), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr), .FLASH_ADDR_O(faddr),
        .FLASH_INFO_SEL_O(info), .FLASH_RD_O(rd), .FLASH_DATA_I(fdata), .CORE_RESET_O(core),
        .MOTOR_PINS_ENABLE_O(cfg[20]), .HIGH_SIDE_OFF_LEVEL_O(cfg[19]),
        .LOW_SIDE_OFF_LEVEL_O(cfg[18]), .EXTERNAL_BUS_WIDE_SELECT_O(cfg[17]),
        .SYSCLK_DIV8_O(cfg[16]), .OSC_TEMPERATURE_TRIM_O(cfg[15:13]),
        .OSC_FREQUENCY_TRIM_O(cfg[12:8]), .OSC_FREQUENCY_TRIM2_O(cfg[7:0]));
    rtlld_flash_model u_flash (.CLOCK_I(clk), .rd_i(rd), .info_i(info), .addr_i(faddr),
        .opt1_i(opt1), .opt3_i(opt3), .trim1_i(t1), .trim2_i(t2), .data_o(fdata));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; read data and error flag land in r and e
    task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wait_load();
        repeat (3) @(negedge clk);
        while (core !== 1'b0) @(negedge clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict();
    end

    initial begin
        srst = 1'b1; reload = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; opt1 = 8'hFA; opt3 = 8'hFF; t1 = 8'hA5; t2 = 8'h3C;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk("core held", 32'h1, {31'h0, core});
        wait_load();
        chk("config", 21'h1AA53C, cfg);
        apb(1'b0, ADDR_TRIM_FIRST, 32'h0);
        chk("trim1 read", 32'hA5, r);
        apb(1'b1, ADDR_TRIM_FIRST, 32'h5A);
        apb(1'b0, ADDR_TRIM_FIRST, 32'h0);
        chk("trim1 write", 32'h5A, r);
        apb(1'b1, ADDR_TRIM_SECOND, 32'h77);
        apb(1'b1, ADDR_FACTORY_FIRST, 32'h0);
        chk("factory write error", 32'h1, {31'h0, e});
        apb(1'b0, ADDR_FACTORY_FIRST, 32'h0);
        chk("factory1", 32'hA5, r);
        apb(1'b0, ADDR_FACTORY_SECOND, 32'h0);
        chk("factory2", 32'h3C, r);
        apb(1'b0, 12'h004, 32'h0);
        chk("option hidden", 32'h1, {31'h0, e});
        $display("test first load done");
        opt1 <= 8'hFD; opt3 <= 8'h3F; t1 <= 8'h1E; t2 <= 8'hC3;
        repeat (4) @(negedge clk);
        chk("config kept", 21'h1A5A77, cfg);
        @(posedge clk);
        reload <= 1'b1;
        @(posedge clk);
        reload <= 1'b0;
        wait_load();
        chk("config reload", 21'h051EC3, cfg);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h3, r);
        $display("test reload done");
        print_verdict();
    end
endmodule
`default_nettype wire
